//--- dac_bank_pkg.sv
// Notes on behaviour
// - pin-port write: bit one releases the pin, bit zero drives it low.
// - pin-port read returns the sampled pin levels, not the written value.
// - any reset sets all pin bits to one, reading e000h, pins released.
// - dual supply: each group offset trim defaults to its own code per gain.
// - single supply: offset trim writes ignored and reads return 0000h.
// - dual supply: gain bit change reloads that group's offset trim code.
// - sleep bit one puts the serial interface to sleep; zero is normal.
// - sleep clears on hardware reset and is held clear while wake pin low.
// - sleep routes serial input straight to serial output, bypassing shifter.
// - write to 07h loads all eight data registers, only with correction off.
// - read of the broadcast address always returns 0000h.
// - correction on: codes go to input register; off: to data register.
// - channel output changes only when data moves into its output latch, or on soft reset, which clears it.
// - each channel input code register resets to 0000h.
// - zero calibration is a two's complement offset, one code per step.
// - eight zero calibration registers, each resetting to 0000h.
// - gain calibration is straight binary, 0.5 at 0000h, unity at 8000h.
// - eight gain calibration registers, each resetting to 8000h.
package dac_bank_pkg;

  localparam int unsigned CHANNELS = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SHIFT_LEN = 24;

  // register select codes
  localparam logic [4:0] CONFIG_SEL = 5'h00;
  localparam logic [4:0] GPIO_SEL = 5'h01;
  localparam logic [4:0] OFFSET_A_SEL = 5'h02;
  localparam logic [4:0] OFFSET_B_SEL = 5'h03;
  localparam logic [4:0] SLEEP_SEL = 5'h04;
  localparam logic [4:0] BROADCAST_SEL = 5'h07;
  localparam logic [4:0] INPUT_BASE = 5'h08;
  localparam logic [4:0] ZERO_BASE = 5'h10;
  localparam logic [4:0] GAIN_BASE = 5'h18;

  // field positions
  localparam int unsigned CE_BIT = 9;
  localparam int unsigned GAIN_A_BIT = 8;
  localparam int unsigned GAIN_B_BIT = 7;
  localparam int unsigned SLEEP_BIT = 15;
  localparam int unsigned GPIO_LSB = 13;

  // values after reset
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] GPIO_RESET = 16'he000;
  localparam logic [15:0] TRIM_GAIN6 = 16'h999a;
  localparam logic [15:0] TRIM_GAIN4 = 16'haaab;
  localparam logic [15:0] SLEEP_RESET = 16'h0000;
  localparam logic [15:0] INPUT_RESET = 16'h0000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'h8000;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MAX = 16'hffff;
  // pin order: gpio[2:0], wake_n, dual, sclk, sdi, cs_n
  localparam logic [7:0] PIN_RESET = 8'h8f;

  // one register port request, already decoded from the serial frame
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] sel;
    logic [15:0] data;
  } reg_req_t;

  // factory trim codes of one group
  typedef struct packed {
    logic [15:0] gain6;
    logic [15:0] gain4;
  } group_trim_t;

endpackage

//--- correction_engine.sv
`timescale 1ns/10ps
module correction_engine
  import dac_bank_pkg::*;
(
  input wire logic [15:0] i_code,
  input wire logic [15:0] i_gain,
  input wire logic [15:0] i_zero,
  output logic [15:0] o_result
);

  logic [32:0] product;
  logic [16:0] scaled;
  logic signed [18:0] sum;

  // coefficient is (32768 + gain) / 65536, so 0000h is 0.5, 8000h is 1
  always_comb
  begin
    product = {17'h00000, i_code} * {16'h0000, 17'h08000 + {1'b0, i_gain}};
    scaled = product[32:16];
    sum = $signed({2'b00, scaled}) + $signed({{3{i_zero[15]}}, i_zero});
    // clamp instead of wrapping so an over-range trim cannot fold back
    if (sum < 0)
    begin
      o_result = 16'h0000;
    end
    else if (sum > $signed({3'b000, CODE_MAX}))
    begin
      o_result = CODE_MAX;
    end
    else
    begin
      o_result = sum[15:0];
    end
  end

endmodule

//--- dac_channel_register_bank.sv
`timescale 1ns/10ps
module dac_channel_register_bank #(
  parameter dac_bank_pkg::group_trim_t TRIM_A = {dac_bank_pkg::TRIM_GAIN6,
                                                 dac_bank_pkg::TRIM_GAIN4},
  parameter dac_bank_pkg::group_trim_t TRIM_B = {dac_bank_pkg::TRIM_GAIN6,
                                                 dac_bank_pkg::TRIM_GAIN4}
)(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_soft_reset,
  input wire dac_bank_pkg::reg_req_t i_req,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_latch_load,
  output logic [7:0][15:0] o_channel_level,
  input wire logic [2:0] i_gpio,
  output logic [2:0] o_gpio,
  output logic [2:0] o_gpio_oe_n,
  input wire logic i_wake_pin_n,
  input wire logic i_dual_supply,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_cs_n,
  output logic o_sdo,
  output logic o_sleeping
);
  import dac_bank_pkg::*;

  // true when sel falls in the eight-entry block starting at base
  function automatic logic in_block(input logic [4:0] sel,
                                    input logic [4:0] base);
    in_block = (sel[4:3] == base[4:3]);
  endfunction

  logic [7:0] pin_raw;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic [7:0] pin_s3_q;
  logic [7:0] pin_q;
  logic [15:0] config_q;
  logic [15:0] config_d;
  logic [2:0] gpio_q;
  logic [15:0] offset_a_q;
  logic [15:0] offset_b_q;
  logic sleep_q;
  logic [15:0] input_q [CHANNELS];
  logic [15:0] data_q [CHANNELS];
  logic [15:0] zero_q [CHANNELS];
  logic [15:0] gain_q [CHANNELS];
  logic [2:0] corr_idx_q;
  logic [15:0] corr_result;
  logic [SHIFT_LEN-1:0] shift_q;
  logic sclk_prev_q;
  logic sclk_rise;
  logic ce;
  logic dual;
  logic wr;
  logic [2:0] idx;

  assign pin_raw = {i_cs_n, i_sdi, i_sclk, i_dual_supply, i_wake_pin_n, i_gpio};
  assign ce = config_q[CE_BIT];
  assign dual = pin_q[4];
  assign wr = i_req.wr;
  assign idx = i_req.sel[2:0];
  assign config_d = i_req.data;
  assign sclk_rise = pin_q[5] & ~sclk_prev_q;

  // three-stage pin sampling; a new level counts once stages two and three agree
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_s1_q <= PIN_RESET;
      pin_s2_q <= PIN_RESET;
      pin_s3_q <= PIN_RESET;
      pin_q <= PIN_RESET;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q))
             | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // configuration: correction enable and the two group gain bits
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      config_q <= CONFIG_RESET;
    end
    else if (i_soft_reset)
    begin
      config_q <= CONFIG_RESET;
    end
    else if (wr && i_req.sel == CONFIG_SEL)
    begin
      config_q <= config_d & ((16'h0001 << CE_BIT) | (16'h0001 << GAIN_A_BIT)
                              | (16'h0001 << GAIN_B_BIT));
    end
  end

  // open-drain pin port; the pins themselves never drive high
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      gpio_q <= GPIO_RESET[GPIO_LSB +: 3];
    end
    else if (i_soft_reset)
    begin
      gpio_q <= GPIO_RESET[GPIO_LSB +: 3];
    end
    else if (wr && i_req.sel == GPIO_SEL)
    begin
      gpio_q <= i_req.data[GPIO_LSB +: 3];
    end
  end

  assign o_gpio = 3'h0;
  assign o_gpio_oe_n = gpio_q;

  // offset trims; with dual supply, a gain change reloads the matching factory code
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      // each group starts from its own trimmed code, not a shared one
      offset_a_q <= TRIM_A.gain6;
      offset_b_q <= TRIM_B.gain6;
    end
    else if (i_soft_reset)
    begin
      offset_a_q <= TRIM_A.gain6;
      offset_b_q <= TRIM_B.gain6;
    end
    else if (dual && wr)
    begin
      if (i_req.sel == CONFIG_SEL
          && config_d[GAIN_A_BIT] != config_q[GAIN_A_BIT])
      begin
        offset_a_q <= config_d[GAIN_A_BIT] ? TRIM_A.gain4
                                           : TRIM_A.gain6;
      end
      if (i_req.sel == CONFIG_SEL
          && config_d[GAIN_B_BIT] != config_q[GAIN_B_BIT])
      begin
        offset_b_q <= config_d[GAIN_B_BIT] ? TRIM_B.gain4
                                           : TRIM_B.gain6;
      end
      if (i_req.sel == OFFSET_A_SEL)
      begin
        offset_a_q <= i_req.data;
      end
      if (i_req.sel == OFFSET_B_SEL)
      begin
        offset_b_q <= i_req.data;
      end
    end
  end

  // sleep bit: soft reset leaves it alone; the reset pin or a low wake pin clears it
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sleep_q <= SLEEP_RESET[SLEEP_BIT];
    end
    else if (!pin_q[3])
    begin
      sleep_q <= 1'b0;
    end
    else if (wr && i_req.sel == SLEEP_SEL)
    begin
      sleep_q <= i_req.data[SLEEP_BIT];
    end
  end

  assign o_sleeping = sleep_q;

  // serial path: shifter in normal mode, straight feed-through when asleep
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      shift_q <= '0;
      sclk_prev_q <= 1'b0;
      o_sdo <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= pin_q[5];
      if (!sleep_q && !pin_q[7] && sclk_rise)
      begin
        shift_q <= {shift_q[SHIFT_LEN-2:0], pin_q[6]};
      end
      o_sdo <= sleep_q ? pin_q[6] : shift_q[SHIFT_LEN-1];
    end
  end

  // calibration registers and the input codes held for correction
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int n = 0; n < CHANNELS; n++)
      begin
        input_q[n] <= INPUT_RESET;
        zero_q[n] <= ZERO_RESET;
        gain_q[n] <= GAIN_RESET;
      end
    end
    else if (i_soft_reset)
    begin
      for (int n = 0; n < CHANNELS; n++)
      begin
        input_q[n] <= INPUT_RESET;
        zero_q[n] <= ZERO_RESET;
        gain_q[n] <= GAIN_RESET;
      end
    end
    else if (wr)
    begin
      if (ce && in_block(i_req.sel, INPUT_BASE))
      begin
        input_q[idx] <= i_req.data;
      end
      if (in_block(i_req.sel, ZERO_BASE))
      begin
        zero_q[idx] <= i_req.data;
      end
      if (in_block(i_req.sel, GAIN_BASE))
      begin
        gain_q[idx] <= i_req.data;
      end
    end
  end

  correction_engine u_correction (
    .i_code(input_q[corr_idx_q]),
    .i_gain(gain_q[corr_idx_q]),
    .i_zero(zero_q[corr_idx_q]),
    .o_result(corr_result)
  );

  // one channel corrected per clock, so a full sweep takes eight cycles
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      corr_idx_q <= 3'h0;
    end
    else
    begin
      corr_idx_q <= ce ? corr_idx_q + 3'h1 : 3'h0;
    end
  end

  // channel data registers: host, broadcast or correction engine
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int n = 0; n < CHANNELS; n++)
      begin
        data_q[n] <= INPUT_RESET;
      end
    end
    else if (i_soft_reset)
    begin
      for (int n = 0; n < CHANNELS; n++)
      begin
        data_q[n] <= INPUT_RESET;
      end
    end
    else if (ce)
    begin
      data_q[corr_idx_q] <= corr_result;
    end
    else if (wr && i_req.sel == BROADCAST_SEL)
    begin
      for (int n = 0; n < CHANNELS; n++)
      begin
        data_q[n] <= i_req.data;
      end
    end
    else if (wr && in_block(i_req.sel, INPUT_BASE))
    begin
      data_q[idx] <= i_req.data;
    end
  end

  // output latches move only on the load strobe or a soft reset, which clears them
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_channel_level <= '0;
    end
    else if (i_soft_reset)
    begin
      o_channel_level <= '0;
    end
    else if (i_latch_load)
    begin
      for (int n = 0; n < CHANNELS; n++)
      begin
        o_channel_level[n] <= data_q[n];
      end
    end
  end

  // read answer one cycle after the request; unmapped codes read zero
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata <= READ_ZERO;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_req.rd;
      if (i_req.rd)
      begin
        o_rdata <= READ_ZERO;
        if (i_req.sel == CONFIG_SEL)
        begin
          o_rdata <= config_q;
        end
        else if (i_req.sel == GPIO_SEL)
        begin
          o_rdata <= {pin_q[2:0], 13'h0000};
        end
        else if (i_req.sel == OFFSET_A_SEL)
        begin
          o_rdata <= dual ? offset_a_q : READ_ZERO;
        end
        else if (i_req.sel == OFFSET_B_SEL)
        begin
          o_rdata <= dual ? offset_b_q : READ_ZERO;
        end
        else if (i_req.sel == SLEEP_SEL)
        begin
          o_rdata <= {sleep_q, 15'h0000};
        end
        else if (i_req.sel == BROADCAST_SEL)
        begin
          o_rdata <= READ_ZERO;
        end
        else if (in_block(i_req.sel, INPUT_BASE))
        begin
          o_rdata <= ce ? input_q[idx] : data_q[idx];
        end
        else if (in_block(i_req.sel, ZERO_BASE))
        begin
          o_rdata <= zero_q[idx];
        end
        else if (in_block(i_req.sel, GAIN_BASE))
        begin
          o_rdata <= gain_q[idx];
        end
      end
    end
  end

endmodule

//--- host_pins.sv
`timescale 1ns/10ps
module host_pins (
  input wire logic i_clock,
  input wire logic [2:0] i_gpio_oe_n,
  input wire logic [2:0] i_gpio_out,
  input wire logic [2:0] i_pull_low,
  output logic [2:0] o_gpio_level,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_cs_n
);
  // a released pin rises through the board pull-up unless pulled low
  always_comb
    for (int k = 0; k < 3; k++)
      o_gpio_level[k] = !i_gpio_oe_n[k] ? i_gpio_out[k] : !i_pull_low[k];

  // serial clock stands still between frames
  initial
  begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_cs_n = 1'b1;
  end

  // slow bit cells so the sampled copies inside see every edge
  task automatic frame(input logic [23:0] w);
    @(posedge i_clock);
    o_cs_n <= 1'b0;
    for (int k = 23; k >= 0; k--)
    begin
      o_sdi <= w[k];
      repeat (6) @(posedge i_clock);
      o_sclk <= 1'b1;
      repeat (6) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
    repeat (6) @(posedge i_clock);
    o_cs_n <= 1'b1;
    o_sdi <= ~w[0];  // released line must not keep the last bit
  endtask
endmodule

//--- dac_channel_register_bank_asserts.sv
`timescale 1ns/10ps
module dac_channel_register_bank_asserts
  import dac_bank_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_soft_reset,
  input wire dac_bank_pkg::reg_req_t i_req,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_latch_load,
  input wire logic [7:0][15:0] o_channel_level,
  input wire logic [2:0] i_gpio,
  input wire logic [2:0] o_gpio,
  input wire logic [2:0] o_gpio_oe_n,
  input wire logic i_wake_pin_n,
  input wire logic i_dual_supply,
  input wire logic i_sdi,
  input wire logic o_sdo,
  input wire logic o_sleeping
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  // soft reset wins over a same-cycle write to any register but sleep
  wire wr_ok = i_req.wr && !i_soft_reset;
  logic [2:0] pin_wr_q;

  // pin bits of the last request, for the drive check
  always_ff @(posedge i_clock)
    pin_wr_q <= i_req.data[15:13];

  AST_BCAST_RD: assert property (
    i_req.rd && i_req.sel == BROADCAST_SEL |=> o_rvalid && o_rdata == 16'h0)
    else $error("broadcast read not zero");
  AST_NO_RVALID: assert property (!i_req.rd |=> !o_rvalid)
    else $error("read answer without request");
  AST_PIN_DRIVE: assert property (
    wr_ok && i_req.sel == GPIO_SEL |=> o_gpio_oe_n == pin_wr_q && o_gpio == 0)
    else $error("pin enables differ from write");
  AST_SOFT_PINS: assert property (
    i_soft_reset |=> o_gpio_oe_n == 3'b111)
    else $error("pins not released by soft reset");
  AST_PIN_READ: assert property (
    $stable(i_gpio) [*6] ##0 i_req.rd && i_req.sel == GPIO_SEL
    |=> o_rdata == {$past(i_gpio), 13'h0000})
    else $error("pin read differs from pin levels");
  AST_WAKE_CLR: assert property (
    !i_wake_pin_n [*8] |-> !o_sleeping)
    else $error("sleep set while wake pin low");
  AST_SLEEP_SET: assert property (
    i_wake_pin_n [*8] ##0 wr_ok && i_req.sel == SLEEP_SEL && i_req.data[15]
    |=> o_sleeping)
    else $error("sleep bit not set");
  AST_SLEEP_CLR: assert property (
    wr_ok && i_req.sel == SLEEP_SEL && !i_req.data[15] |=> !o_sleeping)
    else $error("sleep bit not cleared");
  AST_BYPASS: assert property (
    (o_sleeping && $stable(i_sdi)) [*8] |-> o_sdo == i_sdi)
    else $error("sleep does not pass serial input");
  AST_SINGLE_RD: assert property (
    !i_dual_supply [*8] ##0 i_req.rd
    && (i_req.sel == OFFSET_A_SEL || i_req.sel == OFFSET_B_SEL)
    |=> o_rdata == 16'h0000)
    else $error("offset read not zero on single supply");
  AST_LATCH_HOLD: assert property (
    !i_latch_load && !i_soft_reset |=> $stable(o_channel_level))
    else $error("channel level moved without load");
endmodule

bind dac_channel_register_bank dac_channel_register_bank_asserts chk_u (
  .i_clock, .i_resetn, .i_soft_reset, .i_req, .o_rdata, .o_rvalid,
  .i_latch_load, .o_channel_level, .i_gpio, .o_gpio, .o_gpio_oe_n,
  .i_wake_pin_n, .i_dual_supply, .i_sdi, .o_sdo, .o_sleeping);

//--- dac_channel_register_bank_bench.sv
`timescale 1ns/10ps
module dac_channel_register_bank_bench;
  import dac_bank_pkg::*;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_soft_reset = 1'b0;
  reg_req_t i_req = '0;
  logic i_latch_load = 1'b0;
  logic i_wake_pin_n = 1'b1;
  logic i_dual_supply = 1'b1;
  logic [2:0] pull_low = 3'b000;
  logic [15:0] o_rdata;
  logic o_rvalid, o_sdo, o_sleeping, sclk, sdi, cs_n;
  logic [7:0][15:0] o_channel_level;
  logic [2:0] o_gpio, o_gpio_oe_n, gpio_level;
  int n_mismatch = 0;
  int compares = 0;
  // gain, zero, expected level for input code 8000h
  logic [15:0] cases [5][3] = '{'{16'h8000, 16'h0010, 16'h8010},
    '{16'hffff, 16'h7fff, 16'hffff}, '{16'h0000, 16'h0000, 16'h4000},
    '{16'hffff, 16'h8000, 16'h3fff}, '{16'h0000, 16'h8000, 16'h0000}};

  // test-only group b codes, differing from group a so a swap shows up
  localparam group_trim_t ALT_TRIM = '{gain6: 16'h999c, gain4: 16'haaa9};

  always #4 i_clock = ~i_clock;

  dac_channel_register_bank #(.TRIM_B(ALT_TRIM)) dut_u (
    .i_clock, .i_resetn, .i_soft_reset, .i_req, .o_rdata, .o_rvalid,
    .i_latch_load, .o_channel_level, .i_gpio(gpio_level), .o_gpio,
    .o_gpio_oe_n, .i_wake_pin_n, .i_dual_supply, .i_sclk(sclk),
    .i_sdi(sdi), .i_cs_n(cs_n), .o_sdo, .o_sleeping);

  host_pins host_u (.i_clock, .i_gpio_oe_n(o_gpio_oe_n), .i_gpio_out(o_gpio),
    .i_pull_low(pull_low), .o_gpio_level(gpio_level), .o_sclk(sclk),
    .o_sdi(sdi), .o_cs_n(cs_n));

  task automatic final_report;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // one request cycle; a fresh edge always passes before the next one
  task automatic access(input logic w, input logic [4:0] s, input logic [15:0] d);
    @(posedge i_clock);
    i_req <= '{wr: w, rd: !w, sel: s, data: d};
    @(posedge i_clock);
    i_req <= '0;
  endtask

  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    access(1'b1, s, d);
  endtask

  task automatic rd(input logic [4:0] s, input logic [15:0] exp);
    access(1'b0, s, 16'h0000);
    #1;
    chk({15'h0000, o_rvalid}, 16'h0001);
    chk(o_rdata, exp);
  endtask

  task automatic load_latch;
    @(posedge i_clock);
    i_latch_load <= 1'b1;
    @(posedge i_clock);
    i_latch_load <= 1'b0;
    #1;
  endtask

  // hang guard, far beyond the thousand or so cycles the tests need
  initial
  begin
    waitc(20000);
    n_mismatch++;
    final_report;
  end

  initial
  begin
    waitc(20);
    i_resetn <= 1'b1;
    waitc(8);
    rd(GPIO_SEL, 16'he000);
    rd(OFFSET_A_SEL, 16'h999a);
    rd(OFFSET_B_SEL, ALT_TRIM.gain6);
    rd(SLEEP_SEL, 16'h0000);
    for (int n = 0; n < 8; n++)
    begin
      rd(INPUT_BASE + 5'(n), 16'h0000);
      rd(ZERO_BASE + 5'(n), 16'h0000);
      rd(GAIN_BASE + 5'(n), 16'h8000);
    end
    wr(GPIO_SEL, 16'h4000);
    waitc(6);
    chk({13'h0000, o_gpio_oe_n}, 16'h0002);
    rd(GPIO_SEL, 16'h4000);
    // pin-side changes go out on a clock edge, never off one
    waitc(1);
    pull_low <= 3'b010;
    waitc(6);
    rd(GPIO_SEL, 16'h0000);
    waitc(1);
    pull_low <= 3'b000;
    wr(OFFSET_A_SEL, 16'h1234);
    wr(CONFIG_SEL, 16'h0100);
    rd(OFFSET_A_SEL, 16'haaab);
    rd(OFFSET_B_SEL, ALT_TRIM.gain6);
    wr(CONFIG_SEL, 16'h0080);
    rd(OFFSET_A_SEL, 16'h999a);
    rd(OFFSET_B_SEL, ALT_TRIM.gain4);
    wr(CONFIG_SEL, 16'h0000);
    rd(OFFSET_B_SEL, ALT_TRIM.gain6);
    waitc(1);
    i_dual_supply <= 1'b0;
    waitc(8);
    wr(OFFSET_B_SEL, 16'h5555);
    rd(OFFSET_B_SEL, 16'h0000);
    waitc(1);
    i_dual_supply <= 1'b1;
    waitc(8);
    rd(OFFSET_B_SEL, ALT_TRIM.gain6);
    wr(OFFSET_B_SEL, 16'h4321);
    wr(GAIN_BASE, 16'h1234);
    @(posedge i_clock);
    i_soft_reset <= 1'b1;
    @(posedge i_clock);
    i_soft_reset <= 1'b0;
    waitc(6);
    rd(GPIO_SEL, 16'he000);
    rd(OFFSET_B_SEL, ALT_TRIM.gain6);
    rd(GAIN_BASE, 16'h8000);
    wr(BROADCAST_SEL, 16'habcd);
    rd(BROADCAST_SEL, 16'h0000);
    for (int n = 0; n < 8; n++)
      rd(INPUT_BASE + 5'(n), 16'habcd);
    chk(o_channel_level[5], 16'h0000);
    load_latch;
    chk(o_channel_level[5], 16'habcd);
    wr(CONFIG_SEL, 16'h0200);
    wr(INPUT_BASE + 5'd3, 16'h8000);
    rd(INPUT_BASE + 5'd3, 16'h8000);
    for (int k = 0; k < 5; k++)
    begin
      wr(GAIN_BASE + 5'd3, cases[k][0]);
      wr(ZERO_BASE + 5'd3, cases[k][1]);
      waitc(10);
      load_latch;
      chk(o_channel_level[3], cases[k][2]);
    end
    wr(CONFIG_SEL, 16'h0000);
    wr(SLEEP_SEL, 16'h8000);
    rd(SLEEP_SEL, 16'h8000);
    // released line ends high; an idle shifter would show low instead
    host_u.frame(24'h800000);
    waitc(8);
    chk({15'h0000, o_sdo}, 16'h0001);
    i_wake_pin_n <= 1'b0;
    waitc(8);
    chk({15'h0000, o_sleeping}, 16'h0000);
    i_wake_pin_n <= 1'b1;
    waitc(8);
    wr(SLEEP_SEL, 16'h8000);
    wr(SLEEP_SEL, 16'h0000);
    rd(SLEEP_SEL, 16'h0000);
    wr(OFFSET_B_SEL, 16'h4321);
    wr(SLEEP_SEL, 16'h8000);
    waitc(1);
    chk({15'h0000, o_sleeping}, 16'h0001);
    // hardware reset in mid-run must clear sleep and restore the trims
    i_resetn <= 1'b0;
    waitc(2);
    i_resetn <= 1'b1;
    waitc(8);
    rd(SLEEP_SEL, 16'h0000);
    rd(OFFSET_B_SEL, ALT_TRIM.gain6);
    host_u.frame(24'h800001);
    waitc(8);
    chk({15'h0000, o_sdo}, 16'h0001);
    final_report;
  end
endmodule
